// ===== hw/hwm_regport.v
// Purpose: indexed register port, config register and interrupt pin gating
// Assumes: host and serial accessors never overlap; one access strobe per cycle
// Notes: monitoring loop is outside; it pushes status bits and value ram bytes
// Operation
// - seven-bit read/write index selects location
// - busy sets on index write, serial transaction
// - busy clears on data access or serial end
// - decode config, status, masks, vid, address, id
// - pair first registers advance index to second
// - self-test ram 00-1F, advance, hold 1F
// - value ram areas; upper advances, stops 7F
// - data port moves selected byte, resets zero
// - config resets with only irq-off set
// - start bit runs monitoring, else standby
// - clearing start keeps interrupt pins asserted
// - bits 1,2 enable the two interrupt outputs
// - irq-off deasserts outputs and halts monitoring
// - reset-pulse bit drives reset low 20 ms
// - bit 5 selects nmi or irq mode
// - bit 6 drives power bypass pin low
// - restore bit resets all but serial address, ram and a running reset pulse
// - reset-pulse needs mask high bit 7 set
// - status read returns and clears, drops line
`timescale 1ns/10ps
`include "hwm_regs_consts.vh"
module hwm_regport #(
   parameter [23:0] RST_PULSE_CYC = `HWM_RST_PULSE_CYC,
   parameter [7:0] CHIP_ID = 8'h11 // arbitrary value
) (
   input wire core_clk_in,
   input wire reset_n_in,
   input wire host_sel_in,
   input wire [3:0] host_port_in,
   input wire host_wr_in,
   input wire host_rd_in,
   input wire [7:0] host_wdata_in,
   output wire [7:0] host_rdata_out,
   input wire ser_active_in,
   input wire ser_idx_wr_in,
   input wire ser_data_wr_in,
   input wire ser_data_rd_in,
   input wire [7:0] ser_wdata_in,
   input wire [3:0] voltage_id_inputs_in,
   input wire [7:0] stat1_set_in,
   input wire [7:0] stat2_set_in,
   input wire val_wr_in,
   input wire [6:0] val_idx_in,
   input wire [7:0] val_data_in,
   output wire monitor_run_out,
   output reg sysmgmt_irq_out,
   output reg host_irq_out,
   output wire host_irq_nmi_mode_out,
   output wire reset_pin_n_out,
   output wire reset_pin_oe_out,
   output wire pwr_bypass_n_out,
   output wire [7:0] sb_addr_out
);
////////////////////////////////////////////////////////////////////////////////
   reg [6:0] index_bits;
   reg busy;
   reg busy_by_host;
   reg [7:0] data_window;
   reg [7:0] cfg;
   reg [7:0] stat1;
   reg [7:0] stat2;
   reg [7:0] smsk1;
   reg [7:0] smsk2;
   reg [7:0] hmsk1;
   reg [7:0] hmsk2;
   reg [3:0] vidfan_hi;
   reg [7:0] sb_addr;
   reg ser_active_d;
   reg [7:0] sel_data;
   reg [6:0] next_index;

   wire [7:0] ram_rdata;
   wire pulse_active;
   wire pulse_done;
   wire restore;
   wire irq_off;
////////////////////////////////////////////////////////////////////////////////
   // merged access strobes from host ports and the serial side
   wire host_idx_wr = host_sel_in && host_wr_in && host_port_in == `HWM_PORT_INDEX;
   wire host_dat_wr = host_sel_in && host_wr_in && host_port_in == `HWM_PORT_DATA;
   wire host_dat_rd = host_sel_in && host_rd_in && host_port_in == `HWM_PORT_DATA;
   wire idx_wr = host_idx_wr || ser_idx_wr_in;
   wire [7:0] idx_wdata = host_idx_wr ? host_wdata_in : ser_wdata_in;
   wire dat_wr = host_dat_wr || ser_data_wr_in;
   wire dat_rd = host_dat_rd || ser_data_rd_in;
   wire [7:0] dat_wdata = host_dat_wr ? host_wdata_in : ser_wdata_in;
   wire dat_acc = dat_wr || dat_rd;
   wire ser_end = ser_active_d && !ser_active_in;
   wire in_ram = index_bits <= `HWM_IDX_VAL1_LAST || index_bits >= `HWM_IDX_VAL2_FIRST;
   wire ram_we = dat_wr && in_ram;
////////////////////////////////////////////////////////////////////////////////
   hwm_ram u_ram (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .wr_en_in(ram_we || val_wr_in),
      .wr_idx_in(ram_we ? index_bits : val_idx_in),
      .wr_data_in(ram_we ? dat_wdata : val_data_in),
      .rd_idx_in(index_bits),
      .rd_data_out(ram_rdata)
   );

   // retrigger blocked in the done cycle, before the pulse bit has dropped
   hwm_pulse #(
      .PULSE_CYC(RST_PULSE_CYC)
   ) u_pulse (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(cfg[`HWM_BIT_RSTPULSE] && smsk2[`HWM_BIT_RST_EN] && !pulse_done),
      .active_out(pulse_active),
      .done_out(pulse_done)
   );
////////////////////////////////////////////////////////////////////////////////
   // read selection for the current index
   always @* begin
      sel_data = 8'h00;
      if (in_ram) begin
         sel_data = ram_rdata;
      end else if (index_bits == `HWM_IDX_CFG) begin
         sel_data = cfg;
      end else if (index_bits == `HWM_IDX_STAT1) begin
         sel_data = stat1;
      end else if (index_bits == `HWM_IDX_STAT2) begin
         sel_data = stat2;
      end else if (index_bits == `HWM_IDX_SMSK1) begin
         sel_data = smsk1;
      end else if (index_bits == `HWM_IDX_SMSK2) begin
         sel_data = smsk2;
      end else if (index_bits == `HWM_IDX_HMSK1) begin
         sel_data = hmsk1;
      end else if (index_bits == `HWM_IDX_HMSK2) begin
         sel_data = hmsk2;
      end else if (index_bits == `HWM_IDX_VIDFAN) begin
         sel_data = {vidfan_hi, voltage_id_inputs_in};
      end else if (index_bits == `HWM_IDX_SBADDR) begin
         sel_data = sb_addr;
      end else if (index_bits == `HWM_IDX_CHIPID) begin
         sel_data = CHIP_ID;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // pointer advance after a data access
   always @* begin
      next_index = index_bits;
      if (index_bits == `HWM_IDX_STAT1 || index_bits == `HWM_IDX_SMSK1 ||
          index_bits == `HWM_IDX_HMSK1) begin
         next_index = index_bits + 7'h01;
      end else if (index_bits < `HWM_IDX_POST_LAST) begin
         next_index = index_bits + 7'h01;
      end else if (index_bits >= `HWM_IDX_VAL2_FIRST && index_bits < `HWM_IDX_VAL2_LAST) begin
         next_index = index_bits + 7'h01;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // index pointer and busy flag
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         index_bits <= 7'h00;
         busy <= 1'b0;
         busy_by_host <= 1'b0;
         ser_active_d <= 1'b0;
      end else if (restore) begin
         // restore returns pointer and busy flag to their power-on values
         index_bits <= 7'h00;
         busy <= 1'b0;
         busy_by_host <= 1'b0;
         ser_active_d <= ser_active_in;
      end else begin
         ser_active_d <= ser_active_in;
         if (idx_wr) begin
            index_bits <= idx_wdata[6:0];
         end else if (dat_acc) begin
            index_bits <= next_index;
         end
         if (host_idx_wr) begin
            busy <= 1'b1;
            busy_by_host <= 1'b1;
         end else if (ser_active_in) begin
            busy <= 1'b1;
         end else if ((dat_acc && busy_by_host) || ser_end) begin
            busy <= 1'b0;
            busy_by_host <= 1'b0;
         end
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // data window latch
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_window <= 8'h00;
      end else if (restore) begin
         data_window <= 8'h00;
      end else if (dat_wr) begin
         data_window <= dat_wdata;
      end else if (dat_rd) begin
         data_window <= sel_data;
      end
   end
   assign host_rdata_out = (host_port_in == `HWM_PORT_INDEX) ? {busy, index_bits} :
                           (host_port_in == `HWM_PORT_DATA) ? sel_data : 8'h00;
////////////////////////////////////////////////////////////////////////////////
   // register writes, status capture and restore
   assign restore = cfg[`HWM_BIT_RESTORE];
   wire wr_cfg = dat_wr && index_bits == `HWM_IDX_CFG;
   wire rd_s1 = dat_rd && index_bits == `HWM_IDX_STAT1;
   wire rd_s2 = dat_rd && index_bits == `HWM_IDX_STAT2;

   // pulse bit held while the pulse runs, dropped after it or without enable
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg <= `HWM_RST_CFG;
      end else if (restore) begin
         cfg <= `HWM_RST_CFG;
      end else if (wr_cfg) begin
         cfg <= dat_wdata;
         if (pulse_active) begin
            cfg[`HWM_BIT_RSTPULSE] <= 1'b1;
         end
      end else if (pulse_done || (cfg[`HWM_BIT_RSTPULSE] && !smsk2[`HWM_BIT_RST_EN])) begin
         cfg[`HWM_BIT_RSTPULSE] <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // event flags: set wins over read-clear

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stat1 <= 8'h00;
         stat2 <= 8'h00;
      end else if (restore) begin
         stat1 <= 8'h00;
         stat2 <= 8'h00;
      end else begin
         stat1 <= (rd_s1 ? 8'h00 : stat1) | (monitor_run_out ? stat1_set_in : 8'h00);
         stat2 <= (rd_s2 ? 8'h00 : stat2) | (monitor_run_out ? {1'b0, stat2_set_in[6:0]} : 8'h00);
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // interrupt masks; mask high bit 7 doubles as the reset-pin enable

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         smsk1 <= 8'h00;
      end else if (restore) begin
         smsk1 <= 8'h00;
      end else if (dat_wr && index_bits == `HWM_IDX_SMSK1) begin
         smsk1 <= dat_wdata;
      end
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         smsk2 <= 8'h00;
      end else if (restore) begin
         smsk2 <= 8'h00;
      end else if (dat_wr && index_bits == `HWM_IDX_SMSK2) begin
         smsk2 <= dat_wdata;
      end
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hmsk1 <= 8'h00;
      end else if (restore) begin
         hmsk1 <= 8'h00;
      end else if (dat_wr && index_bits == `HWM_IDX_HMSK1) begin
         hmsk1 <= dat_wdata;
      end
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hmsk2 <= `HWM_RST_HMSK2;
      end else if (restore) begin
         hmsk2 <= `HWM_RST_HMSK2;
      end else if (dat_wr && index_bits == `HWM_IDX_HMSK2) begin
         hmsk2 <= dat_wdata;
      end
   end

   // upper divisor bits only; the low nibble follows the voltage-id pins
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         vidfan_hi <= `HWM_RST_VIDFAN_HI;
      end else if (restore) begin
         vidfan_hi <= `HWM_RST_VIDFAN_HI;
      end else if (dat_wr && index_bits == `HWM_IDX_VIDFAN) begin
         vidfan_hi <= dat_wdata[7:4];
      end
   end

   // serial address survives a restore
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sb_addr <= `HWM_RST_SBADDR;
      end else if (dat_wr && index_bits == `HWM_IDX_SBADDR) begin
         sb_addr <= dat_wdata;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // interrupt pins, monitor run, reset and bypass pins

   assign irq_off = cfg[`HWM_BIT_IRQ_OFF];
   assign monitor_run_out = cfg[`HWM_BIT_START] && !irq_off;

   // a mask bit of one keeps its flag off the pin
   wire smi_pend = |(stat1 & ~smsk1) || |(stat2[6:0] & ~smsk2[6:0]);
   wire host_pend = |(stat1 & ~hmsk1) || |(stat2[6:0] & ~hmsk2[6:0]);

   // start bit does not enter here, so pins hold when it is cleared
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sysmgmt_irq_out <= 1'b0;
      end else begin
         sysmgmt_irq_out <= smi_pend && cfg[`HWM_BIT_SMI_EN] && !irq_off;
      end
   end

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_irq_out <= 1'b0;
      end else begin
         host_irq_out <= host_pend && cfg[`HWM_BIT_HOST_EN] && !irq_off;
      end
   end

   assign host_irq_nmi_mode_out = cfg[`HWM_BIT_NMI_SEL];
   assign pwr_bypass_n_out = !cfg[`HWM_BIT_PWR_BYP];
   assign sb_addr_out = sb_addr;

   // open-drain reset pin: level fixed low, only the enable moves
   assign reset_pin_n_out = 1'b0;
   assign reset_pin_oe_out = pulse_active;
endmodule

// ===== hw/hwm_regs_consts.vh
// Purpose: shared constants of the indexed register port
// Assumes: 25 MHz core clock
// Notes: offsets are index values or port numbers
`ifndef HWM_REGS_CONSTS_VH
`define HWM_REGS_CONSTS_VH
`define HWM_PORT_INDEX 4'h5
`define HWM_PORT_DATA 4'h6
`define HWM_IDX_CFG 7'h40
`define HWM_IDX_STAT1 7'h41
`define HWM_IDX_STAT2 7'h42
`define HWM_IDX_SMSK1 7'h43
`define HWM_IDX_SMSK2 7'h44
`define HWM_IDX_HMSK1 7'h45
`define HWM_IDX_HMSK2 7'h46
`define HWM_IDX_VIDFAN 7'h47
`define HWM_IDX_SBADDR 7'h48
`define HWM_IDX_CHIPID 7'h49
`define HWM_IDX_POST_LAST 7'h1F
`define HWM_IDX_VAL1_LAST 7'h3F
`define HWM_IDX_VAL2_FIRST 7'h60
`define HWM_IDX_VAL2_LAST 7'h7F
`define HWM_RST_CFG 8'h08
`define HWM_RST_HMSK2 8'h40
`define HWM_RST_SBADDR 8'h2D
`define HWM_RST_VIDFAN_HI 4'h5
`define HWM_BIT_START 0
`define HWM_BIT_SMI_EN 1
`define HWM_BIT_HOST_EN 2
`define HWM_BIT_IRQ_OFF 3
`define HWM_BIT_RSTPULSE 4
`define HWM_BIT_NMI_SEL 5
`define HWM_BIT_PWR_BYP 6
`define HWM_BIT_RESTORE 7
`define HWM_BIT_RST_EN 7
`define HWM_RST_PULSE_MS 24'd20
`define HWM_CLK_KHZ 24'd25000
`define HWM_RST_PULSE_CYC (`HWM_RST_PULSE_MS * `HWM_CLK_KHZ)
`endif

// ===== hw/hwm_ram.v
// Purpose: 128-entry byte storage for both ram areas
// Assumes: one write port, combinational read
// Notes: flip-flop storage addressed by index
`timescale 1ns/10ps
module hwm_ram (
   input wire core_clk_in,
   input wire reset_n_in,
   input wire wr_en_in,
   input wire [6:0] wr_idx_in,
   input wire [7:0] wr_data_in,
   input wire [6:0] rd_idx_in,
   output wire [7:0] rd_data_out
);
   reg [7:0] mem [0:127];
   genvar i;
   generate
      for (i = 0; i < 128; i = i + 1) begin : g_ent
         always @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               mem[i] <= 8'h00;
            end else if (wr_en_in && {25'h0000000, wr_idx_in} == i) begin
               mem[i] <= wr_data_in;
            end
         end
      end
   endgenerate
   assign rd_data_out = mem[rd_idx_in];
endmodule

// ===== hw/hwm_pulse.v
// Purpose: timed low pulse generator
// Assumes: start may stay high for the whole pulse; it is ignored while active
// Notes: count is a parameter so simulation may shorten it
`timescale 1ns/10ps
module hwm_pulse #(
   parameter [23:0] PULSE_CYC = 24'd500000
) (
   input wire core_clk_in,
   input wire reset_n_in,
   input wire start_in,
   output reg active_out,
   output reg done_out
);
   reg [23:0] count;
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count <= 24'h000000;
         active_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !active_out) begin
            active_out <= 1'b1;
            count <= PULSE_CYC - 24'h000001;
         end else if (active_out) begin
            if (count == 24'h000000) begin
               active_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               count <= count - 24'h000001;
            end
         end
      end
   end
endmodule

// ===== dv/hwm_monitor.sv
// Purpose: port checks of the indexed register port
// Assumes: host and serial sides never overlap
// Notes: attached by the bind below
`timescale 1ns/10ps
module hwm_monitor #(
   parameter [23:0] RST_PULSE_CYC = 24'd20
) (
   input wire core_clk_in,
   input wire reset_n_in,
   input wire host_sel_in,
   input wire [3:0] host_port_in,
   input wire host_wr_in,
   input wire host_rd_in,
   input wire [7:0] host_wdata_in,
   input wire [7:0] host_rdata_out,
   input wire ser_active_in,
   input wire ser_data_wr_in,
   input wire monitor_run_out,
   input wire reset_pin_n_out,
   input wire reset_pin_oe_out,
   input wire pwr_bypass_n_out
);
wire p5 = host_sel_in && host_port_in == 4'h5;
wire p6 = host_sel_in && host_port_in == 4'h6;
wire wr_any = (p6 && host_wr_in) || ser_data_wr_in;
reg [23:0] oe_cnt;
always @(posedge core_clk_in or negedge reset_n_in) begin
   if (!reset_n_in) oe_cnt <= 24'h000000;
   else if (reset_pin_oe_out) oe_cnt <= oe_cnt + 24'h000001;
   else oe_cnt <= 24'h000000;
end
////////////////////////////////////////////////////////////
default clocking cb @(posedge core_clk_in); endclocking
default disable iff (!reset_n_in);
chk_index_readback: assert property (
   (p5 && host_wr_in) ##1 (!host_sel_in && !ser_active_in) ##1 (p5 && !ser_active_in)
   |-> host_rdata_out == {1'b1, $past(host_wdata_in[6:0], 2)})
   else $error("index readback wrong");
chk_busy_clear: assert property (
   (p6 && (host_wr_in || host_rd_in) && !ser_active_in) ##1 (!host_sel_in && !ser_active_in)
   ##1 (p5 && !ser_active_in) |-> !host_rdata_out[7])
   else $error("busy not cleared by data access");
chk_serial_busy: assert property (ser_active_in ##1 (ser_active_in && p5) |-> host_rdata_out[7])
   else $error("busy low during serial access");
chk_serial_end: assert property (
   ($fell(ser_active_in) && !(p5 && host_wr_in)) ##1 p5 |-> !host_rdata_out[7])
   else $error("busy stuck after serial access");
chk_other_port: assert property (
   host_sel_in && host_port_in != 4'h5 && host_port_in != 4'h6 |-> host_rdata_out == 8'h00)
   else $error("unmapped port not zero");
chk_pin_low: assert property (reset_pin_n_out == 1'b0)
   else $error("reset pin level not low");
chk_pulse_len: assert property ($fell(reset_pin_oe_out) |-> oe_cnt == RST_PULSE_CYC)
   else $error("reset pulse length wrong");
chk_pulse_cause: assert property ($rose(reset_pin_oe_out) |-> $past(wr_any, 2))
   else $error("reset pulse without write");
chk_bypass_cause: assert property ($changed(pwr_bypass_n_out) |-> $past(wr_any) || $past(wr_any, 2))
   else $error("bypass changed without write");
chk_run_cause: assert property ($changed(monitor_run_out) |-> $past(wr_any) || $past(wr_any, 2))
   else $error("run changed without write");
endmodule
bind hwm_regport hwm_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) hwm_monitor_i (
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .host_sel_in(host_sel_in),
   .host_port_in(host_port_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
   .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out), .ser_active_in(ser_active_in),
   .ser_data_wr_in(ser_data_wr_in), .monitor_run_out(monitor_run_out), .reset_pin_n_out(reset_pin_n_out),
   .reset_pin_oe_out(reset_pin_oe_out), .pwr_bypass_n_out(pwr_bypass_n_out));

// ===== dv/hwm_ser_master.sv
// Purpose: serial-side accessor model
// Assumes: opened only while the host side is idle
// Notes: kind 0 index write, 1 data write, 2 data read
`timescale 1ns/10ps
module hwm_ser_master (
   input wire core_clk_in,
   output reg ser_active_out = 1'b0,
   output reg ser_idx_wr_out = 1'b0,
   output reg ser_data_wr_out = 1'b0,
   output reg ser_data_rd_out = 1'b0,
   output reg [7:0] ser_wdata_out = 8'h00
);
task ser_open;
   @(posedge core_clk_in);
   ser_active_out <= 1'b1;
endtask
task ser_op(input [1:0] kind, input [7:0] d);
   @(posedge core_clk_in);
   ser_idx_wr_out <= kind == 2'd0;
   ser_data_wr_out <= kind == 2'd1;
   ser_data_rd_out <= kind == 2'd2;
   ser_wdata_out <= d;
   @(posedge core_clk_in);
   ser_idx_wr_out <= 1'b0;
   ser_data_wr_out <= 1'b0;
   ser_data_rd_out <= 1'b0;
   ser_wdata_out <= ~d;
endtask
task ser_close;
   @(posedge core_clk_in);
   ser_active_out <= 1'b0;
endtask
endmodule

// ===== dv/tb.sv
// Purpose: directed bench for the indexed register port
// Assumes: shortened reset pulse of 20 clocks
// Notes: host cycles through acc, serial ones through the model
`timescale 1ns/10ps
module tb;
reg clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0, vwr = 1'b0;
reg [3:0] port = 4'h0, vid = 4'hA;
reg [7:0] wd = 8'h00, s1 = 8'h00, s2 = 8'h00, vd = 8'h00, r;
reg [6:0] vi = 7'h00;
wire [7:0] rdata, sba, swd;
wire run, smi, hirq, nmi, rpn, roe, byp_n, sact, siw, sdw, sdr;
integer n_mismatch = 0, n_checks = 0, i;
hwm_regport #(.RST_PULSE_CYC(24'd20), .CHIP_ID(8'h3C)) hwm_regport_i ( // arbitrary id
   .core_clk_in(clk), .reset_n_in(rst_n), .host_sel_in(sel), .host_port_in(port), .host_wr_in(wr),
   .host_rd_in(rd), .host_wdata_in(wd), .host_rdata_out(rdata), .ser_active_in(sact), .ser_idx_wr_in(siw),
   .ser_data_wr_in(sdw), .ser_data_rd_in(sdr), .ser_wdata_in(swd), .voltage_id_inputs_in(vid),
   .stat1_set_in(s1), .stat2_set_in(s2), .val_wr_in(vwr), .val_idx_in(vi), .val_data_in(vd),
   .monitor_run_out(run), .sysmgmt_irq_out(smi), .host_irq_out(hirq), .host_irq_nmi_mode_out(nmi),
   .reset_pin_n_out(rpn), .reset_pin_oe_out(roe), .pwr_bypass_n_out(byp_n), .sb_addr_out(sba));
hwm_ser_master hwm_ser_master_i (.core_clk_in(clk), .ser_active_out(sact), .ser_idx_wr_out(siw),
   .ser_data_wr_out(sdw), .ser_data_rd_out(sdr), .ser_wdata_out(swd));
////////////////////////////////////////////////////////////
initial forever #20 clk = ~clk;
initial begin
   #4000000;
   n_mismatch = n_mismatch + 1;
   test_done;
end
task test_done;
   $display("checks %0d mismatches %0d", n_checks, n_mismatch);
   if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask
task chk8(input string nm, input [7:0] e, input [7:0] g);
   n_checks = n_checks + 1;
   if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
   end
endtask
task chk1(input string nm, input e, input g);
   chk8(nm, {7'h00, e}, {7'h00, g});
endtask
task acc(input [3:0] p, input w, input [7:0] d);
   @(posedge clk);
   sel <= 1'b1;
   port <= p;
   wr <= w;
   rd <= !w;
   wd <= d;
   @(negedge clk);
   r = rdata;
   @(posedge clk);
   sel <= 1'b0;
   wr <= 1'b0;
   rd <= 1'b0;
   // let the taken access settle before anyone looks at the outputs
   @(negedge clk);
endtask
task wreg(input [6:0] x, input [7:0] d);
   acc(4'h5, 1'b1, {1'b0, x});
   acc(4'h6, 1'b1, d);
endtask
task rreg(input [6:0] x, input [7:0] e, input [6:0] nx);
   acc(4'h5, 1'b1, {1'b0, x});
   acc(4'h5, 1'b0, 8'h00);
   chk8("busy_index", {1'b1, x}, r);
   acc(4'h6, 1'b0, 8'h00);
   chk8("data", e, r);
   acc(4'h5, 1'b0, 8'h00);
   chk8("next_index", {1'b0, nx}, r);
endtask
task ev(input [7:0] a, input [7:0] b);
   @(posedge clk);
   s1 <= a; s2 <= b;
   @(posedge clk);
   s1 <= 8'h00; s2 <= 8'h00;
   for (i = 0; i < 8 && smi !== 1'b1 && hirq !== 1'b1; i = i + 1) @(negedge clk);
endtask
initial begin
   repeat (12) @(posedge clk);
   rst_n <= 1'b1;
   rreg(7'h40, 8'h08, 7'h40);
   rreg(7'h41, 8'h00, 7'h42);
   rreg(7'h43, 8'h00, 7'h44);
   rreg(7'h45, 8'h00, 7'h46);
   rreg(7'h46, 8'h40, 7'h46);
   rreg(7'h47, 8'h5A, 7'h47);
   rreg(7'h48, 8'h2D, 7'h48);
   acc(4'h7, 1'b0, 8'h00);
   chk8("other_port", 8'h00, r);
   wreg(7'h49, 8'h00);
   wreg(7'h50, 8'hFF);
   rreg(7'h49, 8'h3C, 7'h49);
   rreg(7'h50, 8'h00, 7'h50);
   $display("done: reset and decode");
   wreg(7'h1E, 8'hAA);
   acc(4'h6, 1'b1, 8'hBB);
   acc(4'h6, 1'b1, 8'hCC);
   rreg(7'h1E, 8'hAA, 7'h1F);
   rreg(7'h1F, 8'hCC, 7'h1F);
   wreg(7'h7E, 8'h11);
   acc(4'h6, 1'b1, 8'h22);
   rreg(7'h7F, 8'h22, 7'h7F);
   @(posedge clk);
   vwr <= 1'b1; vi <= 7'h25; vd <= 8'h5C;
   @(posedge clk);
   vwr <= 1'b0;
   rreg(7'h25, 8'h5C, 7'h25);
   $display("done: ram areas");
   wreg(7'h40, 8'h60);
   chk1("bypass", 1'b0, byp_n);
   chk1("nmi_mode", 1'b1, nmi);
   wreg(7'h40, 8'h03);
   chk1("run", 1'b1, run);
   ev(8'h01, 8'h00);
   chk1("smi", 1'b1, smi);
   wreg(7'h40, 8'h02);
   chk1("smi_kept", 1'b1, smi);
   wreg(7'h40, 8'h0A);
   chk1("run_off", 1'b0, run);
   // interrupt pins are registered: one edge behind the config write
   @(negedge clk);
   chk1("smi_off", 1'b0, smi);
   rreg(7'h41, 8'h01, 7'h42);
   rreg(7'h41, 8'h00, 7'h42);
   wreg(7'h40, 8'h01);
   ev(8'h00, 8'h01);
   chk1("host_masked", 1'b0, hirq);
   wreg(7'h40, 8'h05);
   for (i = 0; i < 8 && hirq !== 1'b1; i = i + 1) @(negedge clk);
   chk1("host_irq", 1'b1, hirq);
   rreg(7'h42, 8'h01, 7'h42);
   chk1("host_drop", 1'b0, hirq);
   $display("done: config and irq");
   wreg(7'h40, 8'h10);
   repeat (3) @(negedge clk);
   chk1("oe_off", 1'b0, roe);
   rreg(7'h40, 8'h00, 7'h40);
   wreg(7'h44, 8'h80);
   wreg(7'h40, 8'h10);
   @(negedge clk);
   chk1("oe_on", 1'b1, roe);
   for (i = 0; i < 60 && roe === 1'b1; i = i + 1) @(negedge clk);
   if (i >= 60) begin
      n_mismatch = n_mismatch + 1;
      test_done;
   end
   rreg(7'h40, 8'h00, 7'h40);
   wreg(7'h48, 8'h33);
   wreg(7'h46, 8'h00);
   wreg(7'h40, 8'h80);
   rreg(7'h40, 8'h08, 7'h40);
   rreg(7'h46, 8'h40, 7'h46);
   chk8("sb_addr", 8'h33, sba);
   $display("done: pulse and restore");
   hwm_ser_master_i.ser_open;
   acc(4'h5, 1'b0, 8'h00);
   chk1("ser_busy", 1'b1, r[7]);
   hwm_ser_master_i.ser_op(2'd0, 8'h43);
   hwm_ser_master_i.ser_op(2'd1, 8'h77);
   hwm_ser_master_i.ser_op(2'd1, 8'h88);
   hwm_ser_master_i.ser_op(2'd0, 8'h45);
   hwm_ser_master_i.ser_op(2'd2, 8'h00);
   hwm_ser_master_i.ser_close;
   acc(4'h5, 1'b0, 8'h00);
   chk8("ser_index", 8'h46, r);
   rreg(7'h43, 8'h77, 7'h44);
   rreg(7'h44, 8'h88, 7'h44);
   $display("done: serial access");
   test_done;
end
endmodule
